/* agcr_top.sv */
// Control and general configuration register bank, addresses 02h to 0Ch
`timescale 1ns/1ps
`include "agcr_defs.svh"
module agcr_top
#(
	parameter int GPIO_WIDTH = 8
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// Register access from the serial port decoder
	input  wire logic        reg_wr_en_in,
	input  wire logic        reg_rd_en_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wr_data_in,
	output logic [7:0]       reg_rd_data_out,
	output logic             reg_rd_valid_out,
	// Serial frame checks
	input  wire logic        frame_done_in,
	input  wire logic [7:0]  frame_sclk_count_in,
	input  wire logic        frame_crc_bad_in,
	// Register map checksum engine
	input  wire logic [15:0] map_crc_calc_in,
	// Pins, clocking and modulator
	input  wire logic [GPIO_WIDTH-1:0] gpio_pin_in,
	input  wire logic [2:0]  clk_div_in,
	input  wire logic        mod_tick_in,
	// Error flags
	output logic             spi_crc_err_out,
	output logic             map_crc_err_out,
	output logic             addr_err_out,
	output logic             sclk_err_out,
	// Conversion control
	output logic             soft_reset_out,
	output logic             conversion_active_out,
	output logic             first_conversion_out,
	output logic             sync_mode_out,
	output logic             standby_power_down_out,
	// General configuration
	output logic [1:0]       speed_mode_out,
	output logic             vcm_enable_out,
	output logic             refp_buffer_enable_out,
	output logic             ref_range_high_out,
	output logic             output_drive_select_out,
	output logic             spi_status_byte_out,
	output logic             spi_crc_enable_out,
	// Data port configuration
	output logic             port_checksum_byte_enable_out,
	output logic             port_status_byte_enable_out,
	output logic [1:0]       lane_count_select_out,
	output logic             chain_mode_select_out,
	output logic [6:0]       port_timing_out
);
	// ****************************************************************
	// Parameter check
	// ****************************************************************
	generate
		if (GPIO_WIDTH < 1 || GPIO_WIDTH > 8)
		begin : g_bad_width
			$error("GPIO_WIDTH must be 1 to 8");
		end
	endgenerate

	// ****************************************************************
	// Storage
	// ****************************************************************
	agcr_pkg::agcr_byte_type csum_hi_reg;
	agcr_pkg::agcr_byte_type csum_lo_reg;
	agcr_pkg::agcr_byte_type gen1_reg;
	agcr_pkg::agcr_byte_type gen2_reg;
	agcr_pkg::agcr_byte_type gen3_reg;
	agcr_pkg::agcr_byte_type dp1_reg;
	agcr_pkg::agcr_byte_type dp2_reg;
	logic [GPIO_WIDTH-1:0]   gpio_meta_reg;
	logic [GPIO_WIDTH-1:0]   gpio_sync_reg;
	logic                    start_pulse_reg;
	logic                    stop_pulse_reg;
	logic [7:0]              tick_count;
	logic [7:0]              rd_next;
	logic                    addr_valid;
	logic                    addr_in_bank;
	logic                    wr_blocked;
	logic                    wr_ok;
	logic                    ctl_wr;
	logic                    key_hit;
	logic                    sync_mode;

	agcr_conv_if conv ();

	// ****************************************************************
	// Access decode
	// ****************************************************************
	assign addr_valid   = (reg_addr_in <= `AGCR_ADDR_LAST_VALID);
	assign addr_in_bank = (reg_addr_in >= `AGCR_ADDR_CSUM_HI)
		&& (reg_addr_in <= `AGCR_ADDR_DP2);
	// Status write stays open so software can clear the blocking flag
	assign wr_blocked   = spi_crc_err_out || addr_err_out || sclk_err_out;
	assign wr_ok        = reg_wr_en_in && addr_in_bank && !wr_blocked;
	assign ctl_wr       = wr_ok && (reg_addr_in == `AGCR_ADDR_CONTROL);
	assign key_hit      = (reg_wr_data_in[`AGCR_CTL_KEY] == `AGCR_RESET_KEY);
	assign sync_mode    = (gen2_reg[`AGCR_G2_MODE] == `AGCR_SYNC_MODE);

	// ****************************************************************
	// Pin sampling
	// ****************************************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			gpio_meta_reg <= '0;
			gpio_sync_reg <= '0;
		end
		else
		begin
			gpio_meta_reg <= gpio_pin_in;
			gpio_sync_reg <= gpio_meta_reg;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in || soft_reset_out)
		begin
			csum_hi_reg <= `AGCR_RST_ZERO;
			csum_lo_reg <= `AGCR_RST_ZERO;
			gen1_reg    <= `AGCR_RST_ZERO;
			gen2_reg    <= `AGCR_RST_GEN2;
			gen3_reg    <= `AGCR_RST_GEN3;
			dp1_reg     <= `AGCR_RST_DP1;
			dp2_reg     <= `AGCR_RST_ZERO;
		end
		else if (wr_ok)
		begin
			case (reg_addr_in)
				`AGCR_ADDR_CSUM_HI: csum_hi_reg <= reg_wr_data_in;
				`AGCR_ADDR_CSUM_LO: csum_lo_reg <= reg_wr_data_in;
				`AGCR_ADDR_GEN1: gen1_reg <= reg_wr_data_in & `AGCR_MASK_GEN1;
				`AGCR_ADDR_GEN2: gen2_reg <= reg_wr_data_in & `AGCR_MASK_GEN2;
				`AGCR_ADDR_GEN3: gen3_reg <= reg_wr_data_in & `AGCR_MASK_GEN3;
				`AGCR_ADDR_DP1:  dp1_reg  <= reg_wr_data_in & `AGCR_MASK_DP1;
				`AGCR_ADDR_DP2:  dp2_reg  <= reg_wr_data_in & `AGCR_MASK_DP2;
				default:         csum_hi_reg <= csum_hi_reg;
			endcase
		end
	end

	// ****************************************************************
	// Control strobes
	// ****************************************************************
	// A key write carrying start or stop is not honoured as either
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			soft_reset_out <= 1'b0;
		else
			soft_reset_out <= ctl_wr && key_hit;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in || soft_reset_out)
		begin
			start_pulse_reg <= 1'b0;
			stop_pulse_reg  <= 1'b0;
		end
		else
		begin
			start_pulse_reg <= ctl_wr && !key_hit && !sync_mode
				&& reg_wr_data_in[`AGCR_CTL_START];
			stop_pulse_reg  <= ctl_wr && !key_hit && !sync_mode
				&& reg_wr_data_in[`AGCR_CTL_STOP];
		end
	end

	assign conv.start_req  = start_pulse_reg;
	assign conv.stop_req   = stop_pulse_reg;
	assign conv.soft_rst   = soft_reset_out;
	assign conv.delay_code = gen1_reg[`AGCR_G1_DELAY];

	// ****************************************************************
	// Sequencer and tick counter
	// ****************************************************************
	agcr_conv_sequencer agcr_conv_sequencer_inst
	(
		.clk_in      (clk_in),
		.sys_rst_in  (sys_rst_in),
		.mod_tick_in (mod_tick_in),
		.conv        (conv.seq)
	);

	agcr_tick_counter agcr_tick_counter_inst
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.enable_in  (gen3_reg[`AGCR_G3_TICK_EN]),
		.clk_div_in (clk_div_in),
		.count_out  (tick_count)
	);

	// ****************************************************************
	// Error flags, set wins over clear
	// ****************************************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in || soft_reset_out)
		begin
			spi_crc_err_out <= 1'b0;
			map_crc_err_out <= 1'b0;
			addr_err_out    <= 1'b0;
			sclk_err_out    <= 1'b0;
		end
		else
		begin
			spi_crc_err_out <= (frame_crc_bad_in && gen3_reg[`AGCR_G3_SPI_CRC])
				|| (spi_crc_err_out && !(reg_wr_en_in
				&& reg_addr_in == `AGCR_ADDR_STATUS
				&& reg_wr_data_in[`AGCR_ST_SPI_ERR]));
			map_crc_err_out <= (gen3_reg[`AGCR_G3_MAP_CRC]
				&& {csum_hi_reg, csum_lo_reg} != map_crc_calc_in)
				|| (map_crc_err_out && !(reg_wr_en_in
				&& reg_addr_in == `AGCR_ADDR_STATUS
				&& reg_wr_data_in[`AGCR_ST_MAP_ERR]));
			addr_err_out    <= ((reg_wr_en_in || reg_rd_en_in) && !addr_valid
				&& gen3_reg[`AGCR_G3_ADDR_EN])
				|| (addr_err_out && !(reg_wr_en_in
				&& reg_addr_in == `AGCR_ADDR_STATUS
				&& reg_wr_data_in[`AGCR_ST_ADDR_ERR]));
			sclk_err_out    <= (frame_done_in && gen3_reg[`AGCR_G3_SCLK_EN]
				&& (frame_sclk_count_in % 8'(`AGCR_SCLK_MULT)) != 8'h00)
				|| (sclk_err_out && !(reg_wr_en_in
				&& reg_addr_in == `AGCR_ADDR_STATUS
				&& reg_wr_data_in[`AGCR_ST_SCLK_ERR]));
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_comb
	begin
		rd_next = 8'h00;
		case (reg_addr_in)
			`AGCR_ADDR_STATUS:
			begin
				rd_next[`AGCR_ST_SPI_ERR]  = spi_crc_err_out;
				rd_next[`AGCR_ST_MAP_ERR]  = map_crc_err_out;
				rd_next[`AGCR_ST_ADDR_ERR] = addr_err_out;
				rd_next[`AGCR_ST_SCLK_ERR] = sclk_err_out;
			end
			`AGCR_ADDR_TICK:    rd_next = tick_count;
			`AGCR_ADDR_GPIO_RB: rd_next = 8'(gpio_sync_reg);
			`AGCR_ADDR_CSUM_HI: rd_next = csum_hi_reg;
			`AGCR_ADDR_CSUM_LO: rd_next = csum_lo_reg;
			`AGCR_ADDR_CONTROL: rd_next = 8'h00;
			`AGCR_ADDR_GEN1:    rd_next = gen1_reg;
			`AGCR_ADDR_GEN2:    rd_next = gen2_reg;
			`AGCR_ADDR_GEN3:    rd_next = gen3_reg;
			`AGCR_ADDR_DP1:     rd_next = dp1_reg;
			`AGCR_ADDR_DP2:     rd_next = dp2_reg;
			default:            rd_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			reg_rd_data_out  <= 8'h00;
			reg_rd_valid_out <= 1'b0;
		end
		else
		begin
			reg_rd_valid_out <= reg_rd_en_in;
			if (reg_rd_en_in)
				reg_rd_data_out <= rd_next;
		end
	end

	// ****************************************************************
	// Registered configuration outputs
	// ****************************************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			conversion_active_out  <= 1'b0;
			first_conversion_out   <= 1'b0;
			sync_mode_out          <= 1'b0;
			standby_power_down_out <= 1'b0;
		end
		else
		begin
			conversion_active_out  <= conv.active;
			first_conversion_out   <= conv.first_conv;
			sync_mode_out          <= sync_mode;
			// Only meaningful while stopped; running keeps analog up
			standby_power_down_out <= gen2_reg[`AGCR_G2_STBY] && !conv.active;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			speed_mode_out                <= `AGCR_RST_SPEED;
			vcm_enable_out                <= 1'b0;
			refp_buffer_enable_out        <= 1'b0;
			ref_range_high_out            <= 1'b0;
			output_drive_select_out       <= 1'b1;
			spi_status_byte_out           <= 1'b0;
			spi_crc_enable_out            <= 1'b0;
			port_checksum_byte_enable_out <= 1'b0;
			port_status_byte_enable_out   <= 1'b0;
			lane_count_select_out         <= `AGCR_RST_LANES;
			chain_mode_select_out         <= 1'b0;
			port_timing_out               <= 7'h00;
		end
		else
		begin
			speed_mode_out                <= gen2_reg[`AGCR_G2_SPEED];
			vcm_enable_out                <= gen1_reg[`AGCR_G1_VCM];
			refp_buffer_enable_out        <= gen1_reg[`AGCR_G1_REFP];
			ref_range_high_out            <= gen1_reg[`AGCR_G1_RANGE];
			output_drive_select_out       <= gen3_reg[`AGCR_G3_DRV];
			spi_status_byte_out           <= gen3_reg[`AGCR_G3_SPI_STAT];
			spi_crc_enable_out            <= gen3_reg[`AGCR_G3_SPI_CRC];
			port_checksum_byte_enable_out <= dp1_reg[`AGCR_DP1_CRC];
			port_status_byte_enable_out   <= dp1_reg[`AGCR_DP1_STAT];
			lane_count_select_out         <= dp1_reg[`AGCR_DP1_LANES];
			chain_mode_select_out         <= dp1_reg[`AGCR_DP1_CHAIN];
			port_timing_out               <= dp2_reg[`AGCR_DP2_TIMING];
		end
	end
endmodule

/* agcr_defs.svh */
// Addresses, field positions, reset values and timing constants of the config bank
`ifndef AGCR_DEFS_SVH
`define AGCR_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define AGCR_ADDR_STATUS     8'h02
`define AGCR_ADDR_TICK       8'h03
`define AGCR_ADDR_GPIO_RB    8'h04
`define AGCR_ADDR_CSUM_HI    8'h05
`define AGCR_ADDR_CSUM_LO    8'h06
`define AGCR_ADDR_CONTROL    8'h07
`define AGCR_ADDR_GEN1       8'h08
`define AGCR_ADDR_GEN2       8'h09
`define AGCR_ADDR_GEN3       8'h0a
`define AGCR_ADDR_DP1        8'h0b
`define AGCR_ADDR_DP2        8'h0c
`define AGCR_ADDR_LAST_VALID 8'h50

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define AGCR_RST_ZERO  8'h00
`define AGCR_RST_GEN2  8'h04
`define AGCR_RST_GEN3  8'h80
`define AGCR_RST_DP1   8'h20
`define AGCR_RST_SPEED 2'h2
`define AGCR_RST_LANES 2'h2
`define AGCR_MASK_GEN1 8'h3f
`define AGCR_MASK_GEN2 8'h1f
`define AGCR_MASK_GEN3 8'hbf
`define AGCR_MASK_DP1  8'hf2
`define AGCR_MASK_DP2  8'h7f

// ****************************************************************
// Field positions
// ****************************************************************
`define AGCR_CTL_START     1
`define AGCR_CTL_STOP      0
`define AGCR_RESET_KEY     6'h16
`define AGCR_SYNC_MODE     2'h2
`define AGCR_G3_DRV        7
`define AGCR_G3_TICK_EN    5
`define AGCR_G3_SPI_STAT   4
`define AGCR_G3_ADDR_EN    3
`define AGCR_G3_SCLK_EN    2
`define AGCR_G3_SPI_CRC    1
`define AGCR_G3_MAP_CRC    0
`define AGCR_DP1_CRC       7
`define AGCR_DP1_STAT      6
`define AGCR_DP1_CHAIN     1
`define AGCR_ST_SPI_ERR    4
`define AGCR_ST_MAP_ERR    3
`define AGCR_ST_ADDR_ERR   1
`define AGCR_ST_SCLK_ERR   0
`define AGCR_CTL_KEY       7:2
`define AGCR_G1_DELAY      5:3
`define AGCR_G1_VCM        2
`define AGCR_G1_REFP       1
`define AGCR_G1_RANGE      0
`define AGCR_G2_MODE       4:3
`define AGCR_G2_SPEED      2:1
`define AGCR_G2_STBY       0
`define AGCR_DP1_LANES     5:4
`define AGCR_DP2_TIMING    6:0

// ****************************************************************
// Timing
// ****************************************************************
`define AGCR_TICK_BASE     32
`define AGCR_SCLK_MULT     8
`define AGCR_DIV_MAX       8
`define AGCR_DLY_1         11'd4
`define AGCR_DLY_2         11'd8
`define AGCR_DLY_3         11'd16
`define AGCR_DLY_4         11'd32
`define AGCR_DLY_5         11'd128
`define AGCR_DLY_6         11'd512
`define AGCR_DLY_7         11'd1024

`endif

/* agcr_pkg.sv */
// Types shared by the config bank modules
package agcr_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_RUN} agcr_seq_state_type;
	typedef logic [7:0] agcr_byte_type;
endpackage

/* agcr_conv_if.sv */
// Conversion control carrier between register bank and sequencer
`timescale 1ns/1ps
interface agcr_conv_if;
	logic       start_req;
	logic       stop_req;
	logic       soft_rst;
	logic [2:0] delay_code;
	logic       active;
	logic       first_conv;

	modport ctrl
	(
		output start_req,
		output stop_req,
		output soft_rst,
		output delay_code,
		input  active,
		input  first_conv
	);
	modport seq
	(
		input  start_req,
		input  stop_req,
		input  soft_rst,
		input  delay_code,
		output active,
		output first_conv
	);
endinterface

/* agcr_tick_counter.sv */
// ADC clock tick counter with divider-scaled prescaler
`timescale 1ns/1ps
`include "agcr_defs.svh"
module agcr_tick_counter
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// Control
	input  wire logic       enable_in,
	input  wire logic [2:0] clk_div_in,
	// Count
	output logic [7:0]      count_out
);
	logic [7:0] prescale_reg;
	logic [7:0] limit;

	// Ratio 1..4 for codes 0..3, otherwise 8
	always_comb
	begin
		if (clk_div_in[2])
			limit = 8'(`AGCR_TICK_BASE * `AGCR_DIV_MAX - 1);
		else
			limit = 8'(`AGCR_TICK_BASE * ({1'b0, clk_div_in[1:0]} + 3'd1) - 1);
	end

	// Held at zero while disabled, so enabling restarts from zero
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			prescale_reg <= 8'h00;
		else if (!enable_in || prescale_reg >= limit)
			prescale_reg <= 8'h00;
		else
			prescale_reg <= prescale_reg + 8'h01;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			count_out <= 8'h00;
		else if (!enable_in)
			count_out <= 8'h00;
		else if (prescale_reg >= limit)
			count_out <= count_out + 8'h01;
	end
endmodule

/* agcr_conv_sequencer.sv */
// Start/stop sequencer with programmable start delay in modulator cycles
`timescale 1ns/1ps
`include "agcr_defs.svh"
module agcr_conv_sequencer
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Modulator clock enable
	input  wire logic mod_tick_in,
	// Bank side
	agcr_conv_if.seq  conv
);
	agcr_pkg::agcr_seq_state_type state_reg;
	logic [10:0] wait_reg;
	logic [10:0] target;
	logic        first_reg;

	always_comb
	begin
		case (conv.delay_code)
			3'd0: target = 11'd0;
			3'd1: target = `AGCR_DLY_1;
			3'd2: target = `AGCR_DLY_2;
			3'd3: target = `AGCR_DLY_3;
			3'd4: target = `AGCR_DLY_4;
			3'd5: target = `AGCR_DLY_5;
			3'd6: target = `AGCR_DLY_6;
			default: target = `AGCR_DLY_7;
		endcase
	end

	// A start while running restarts the delay; stop wins over start
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_reg <= agcr_pkg::SEQ_IDLE;
			wait_reg  <= 11'd0;
			first_reg <= 1'b0;
		end
		else
		begin
			first_reg <= 1'b0;
			if (conv.soft_rst || conv.stop_req)
				state_reg <= agcr_pkg::SEQ_IDLE;
			else if (conv.start_req)
			begin
				wait_reg <= 11'd0;
				if (target == 11'd0)
				begin
					state_reg <= agcr_pkg::SEQ_RUN;
					first_reg <= 1'b1;
				end
				else
					state_reg <= agcr_pkg::SEQ_WAIT;
			end
			else
			begin
				case (state_reg)
					agcr_pkg::SEQ_WAIT:
						if (mod_tick_in)
						begin
							wait_reg <= wait_reg + 11'd1;
							if (wait_reg == target - 11'd1)
							begin
								state_reg <= agcr_pkg::SEQ_RUN;
								first_reg <= 1'b1;
							end
						end
					agcr_pkg::SEQ_RUN:  state_reg <= agcr_pkg::SEQ_RUN;
					agcr_pkg::SEQ_IDLE: state_reg <= agcr_pkg::SEQ_IDLE;
					default:            state_reg <= agcr_pkg::SEQ_IDLE;
				endcase
			end
		end
	end

	assign conv.active     = (state_reg == agcr_pkg::SEQ_RUN);
	assign conv.first_conv = first_reg;
endmodule

/* agcr_top_asserts.sv */
// Port-level property checker for the config register bank
`timescale 1ns/1ps
module agcr_top_asserts
#(
	parameter int GPIO_WIDTH = 8
)
(
	// Clock and reset
	input wire logic                  clk_in,
	input wire logic                  sys_rst_in,
	// Register port
	input wire logic                  reg_wr_en_in,
	input wire logic                  reg_rd_en_in,
	input wire logic [7:0]            reg_addr_in,
	input wire logic [7:0]            reg_wr_data_in,
	input wire logic [7:0]            reg_rd_data_out,
	input wire logic                  reg_rd_valid_out,
	// Frame checks and pins
	input wire logic                  frame_done_in,
	input wire logic [7:0]            frame_sclk_count_in,
	input wire logic                  frame_crc_bad_in,
	input wire logic [GPIO_WIDTH-1:0] gpio_pin_in,
	// Flags and control
	input wire logic                  spi_crc_err_out,
	input wire logic                  addr_err_out,
	input wire logic                  sclk_err_out,
	input wire logic                  soft_reset_out,
	input wire logic                  conversion_active_out,
	input wire logic                  first_conversion_out,
	input wire logic                  standby_power_down_out,
	input wire logic [1:0]            speed_mode_out,
	input wire logic                  output_drive_select_out
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	logic blk;
	// Writes are blocked while any port fault flag stands
	assign blk = spi_crc_err_out | addr_err_out | sclk_err_out;
	a_read_answer_latency: assert property (reg_rd_en_in |=> reg_rd_valid_out)
		else $error("read answer missing");
	a_ctrl_reads_zero: assert property (reg_rd_en_in && reg_addr_in == 8'h07 |=> reg_rd_data_out == 8'h00)
		else $error("control byte not zero");
	a_key_soft_reset: assert property (reg_wr_en_in && reg_addr_in == 8'h07 && reg_wr_data_in == 8'h58 && !blk |=> soft_reset_out)
		else $error("key gave no reset");
	a_soft_reset_clears: assert property (soft_reset_out |-> ##2 (speed_mode_out == 2'b10 && output_drive_select_out))
		else $error("config not back to reset");
	a_addr_err_cause: assert property ($rose(addr_err_out) |-> $past((reg_rd_en_in | reg_wr_en_in) && reg_addr_in > 8'h50))
		else $error("address flag without cause");
	a_sclk_err_cause: assert property ($rose(sclk_err_out) |-> $past(frame_done_in && frame_sclk_count_in[2:0] != 3'h0))
		else $error("count flag without cause");
	a_spi_err_cause: assert property ($rose(spi_crc_err_out) |-> $past(frame_crc_bad_in))
		else $error("crc flag without cause");
	a_first_when_active: assert property (first_conversion_out |-> conversion_active_out)
		else $error("first conversion while idle");
	a_standby_stopped: assert property (standby_power_down_out |-> !conversion_active_out)
		else $error("standby while running");
	a_gpio_readback: assert property (reg_rd_en_in && reg_addr_in == 8'h04 && $past(gpio_pin_in, 1) == gpio_pin_in && $past(gpio_pin_in, 2) == gpio_pin_in |=> reg_rd_data_out[GPIO_WIDTH-1:0] == $past(gpio_pin_in))
		else $error("pin readback wrong");
endmodule

bind agcr_top agcr_top_asserts #(.GPIO_WIDTH(GPIO_WIDTH)) agcr_top_asserts_inst (.*);

/* agcr_mod_source.sv */
// Modulator cycle enable source for the far side of the bank
`timescale 1ns/1ps
module agcr_mod_source
#(
	parameter int DIV = 4
)
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Modulator cycle enable
	output logic      mod_tick_out
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			cnt_reg      <= 8'h00;
			mod_tick_out <= 1'b0;
		end
		else
		begin
			cnt_reg      <= (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
			mod_tick_out <= (cnt_reg == 8'(DIV - 1));
		end
	end
endmodule

/* tb_adc_general_config_registers.sv */
// Self-checking bench for the config register bank
`timescale 1ns/1ps
module tb_adc_general_config_registers;
	logic        clk_in, sys_rst_in, reg_wr_en_in, reg_rd_en_in, frame_done_in;
	logic        frame_crc_bad_in, mod_tick_in, reg_rd_valid_out, spi_crc_err_out;
	logic        map_crc_err_out, addr_err_out, sclk_err_out, soft_reset_out;
	logic        conversion_active_out, first_conversion_out, sync_mode_out;
	logic        standby_power_down_out, vcm_enable_out, refp_buffer_enable_out;
	logic        ref_range_high_out, output_drive_select_out, spi_status_byte_out;
	logic        spi_crc_enable_out, port_checksum_byte_enable_out;
	logic        port_status_byte_enable_out, chain_mode_select_out;
	logic [1:0]  speed_mode_out, lane_count_select_out;
	logic [2:0]  clk_div_in;
	logic [6:0]  port_timing_out;
	logic [7:0]  reg_addr_in, reg_wr_data_in, reg_rd_data_out, frame_sclk_count_in, gpio_pin_in;
	logic [15:0] map_crc_calc_in;
	logic [7:0]  cfg_pack, gen_pack;
	int          miscompares, compares, i;
	logic [7:0]  rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h80, 8'h20, 8'h00};
	logic [7:0]  msk_tab [10] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h3f, 8'h1f, 8'hbf, 8'hf2, 8'h7f};
	assign cfg_pack = {port_checksum_byte_enable_out, port_status_byte_enable_out,
		lane_count_select_out, chain_mode_select_out, output_drive_select_out, speed_mode_out};
	assign gen_pack = {1'b0, map_crc_err_out, addr_err_out, vcm_enable_out,
		refp_buffer_enable_out, ref_range_high_out, spi_status_byte_out, spi_crc_enable_out};
	agcr_top agcr_top_inst (.*);
	agcr_mod_source agcr_mod_source_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mod_tick_out(mod_tick_in));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_en_in   <= 1'b1;
		reg_addr_in    <= a;
		reg_wr_data_in <= d;
		@(posedge clk_in);
		reg_wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		int k;
		repeat (2) @(posedge clk_in);
		reg_rd_en_in <= 1'b1;
		reg_addr_in  <= a;
		@(posedge clk_in);
		reg_rd_en_in <= 1'b0;
		#1;
		for (k = 0; k < 4 && reg_rd_valid_out !== 1'b1; k++)
			@(posedge clk_in) #1;
		if (reg_rd_valid_out !== 1'b1)
			chk("read valid", 8'h01, 8'h00);
		if (reg_rd_valid_out !== 1'b1)
			summarize();
		chk($sformatf("reg %h", a), e, reg_rd_data_out);
	endtask
	task automatic frame(input logic [7:0] n, input logic bad);
		@(posedge clk_in);
		frame_done_in       <= 1'b1;
		frame_sclk_count_in <= n;
		frame_crc_bad_in    <= bad;
		@(posedge clk_in);
		frame_done_in    <= 1'b0;
		frame_crc_bad_in <= 1'b0;
	endtask
	task automatic wact(input logic e);
		int k;
		for (k = 0; k < 200 && conversion_active_out !== e; k++)
			@(posedge clk_in) #1;
		chk("active", {7'h00, e}, {7'h00, conversion_active_out});
		if (conversion_active_out !== e)
			summarize();
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic rst_chk();
		for (i = 0; i < 10; i++)
			rd(8'(3 + i), rst_tab[i]);
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	initial
	begin
		sys_rst_in = 1'b1;
		reg_wr_en_in = 1'b0;
		reg_rd_en_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wr_data_in = 8'h00;
		frame_done_in = 1'b0;
		frame_crc_bad_in = 1'b0;
		frame_sclk_count_in = 8'h00;
		map_crc_calc_in = 16'h0000;
		gpio_pin_in = 8'h00;
		clk_div_in = 3'h0;
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rst_chk();
		chk("cfg", 8'h26, cfg_pack);
		chk("gen", 8'h00, gen_pack);
		tend("reset");
		for (i = 0; i < 10; i++)
			wr(8'(3 + i), 8'hff);
		for (i = 0; i < 10; i++)
			rd(8'(3 + i), msk_tab[i]);
		rd(8'h0d, 8'h00);
		chk("cfg", 8'hff, cfg_pack);
		chk("gen", 8'h5f, gen_pack);
		chk("timing", 8'h7f, {1'b0, port_timing_out});
		tend("fill");
		wr(8'h07, 8'h58);
		repeat (3) @(posedge clk_in);
		rst_chk();
		tend("soft reset");
		wr(8'h0a, 8'h20);
		repeat (100) @(posedge clk_in);
		rd(8'h03, 8'h03);
		wr(8'h0a, 8'h00);
		rd(8'h03, 8'h00);
		clk_div_in <= 3'h5;
		wr(8'h0a, 8'h20);
		repeat (300) @(posedge clk_in);
		rd(8'h03, 8'h01);
		wr(8'h0a, 8'h00);
		tend("tick");
		map_crc_calc_in <= 16'h1234;
		wr(8'h0a, 8'h01);
		rd(8'h02, 8'h08);
		wr(8'h05, 8'h12);
		wr(8'h06, 8'h34);
		wr(8'h02, 8'h08);
		rd(8'h02, 8'h00);
		wr(8'h0a, 8'h04);
		frame(8'd13, 1'b0);
		rd(8'h02, 8'h01);
		wr(8'h08, 8'h38);
		rd(8'h08, 8'h00);
		wr(8'h02, 8'h01);
		frame(8'd16, 1'b0);
		rd(8'h02, 8'h00);
		wr(8'h0a, 8'h02);
		frame(8'd16, 1'b1);
		rd(8'h02, 8'h10);
		wr(8'h02, 8'h10);
		rd(8'h02, 8'h00);
		wr(8'h0a, 8'h08);
		rd(8'h51, 8'h00);
		rd(8'h02, 8'h02);
		wr(8'h02, 8'h02);
		wr(8'h08, 8'h08);
		rd(8'h08, 8'h08);
		wr(8'h0a, 8'h00);
		tend("flags");
		wr(8'h07, 8'h02);
		repeat (12) @(posedge clk_in);
		#1;
		chk("early", 8'h00, {7'h00, conversion_active_out});
		wact(1'b1);
		wr(8'h07, 8'h01);
		wact(1'b0);
		wr(8'h08, 8'h00);
		wr(8'h07, 8'h02);
		repeat (2) @(posedge clk_in);
		#1;
		chk("active", 8'h01, {7'h00, conversion_active_out});
		chk("first", 8'h01, {7'h00, first_conversion_out});
		wr(8'h09, 8'h10);
		wr(8'h07, 8'h01);
		repeat (4) @(posedge clk_in);
		#1;
		chk("sync stop", 8'h01, {7'h00, conversion_active_out});
		wr(8'h09, 8'h00);
		wr(8'h07, 8'h01);
		wact(1'b0);
		wr(8'h09, 8'h10);
		wr(8'h07, 8'h02);
		repeat (10) @(posedge clk_in);
		#1;
		chk("sync", 8'h01, {7'h00, sync_mode_out});
		chk("active", 8'h00, {7'h00, conversion_active_out});
		wr(8'h09, 8'h01);
		repeat (3) @(posedge clk_in);
		chk("standby", 8'h01, {7'h00, standby_power_down_out});
		tend("conversion");
		gpio_pin_in <= 8'ha5;
		repeat (3) @(posedge clk_in);
		rd(8'h04, 8'ha5);
		tend("gpio");
		summarize();
	end
endmodule
